// ==== gsp_map.vh ====
// register map, field positions and reset values of the global strap and status pin block
// Overview of operation
// - A low global reset pin forces every internal flop to its default, without the clock, for as long as it stays low.
// - When reset is released the fast source-switch pin level is captured as the external-switching enable.
// - After release, and only with external switching enabled, the source-switch pin picks the 3/5 or the 4/6 input pair.
// - At release the rate-family strap is copied into the rate-family bit and both output rate selects, 0 SDH and 1 SONET.
// - After reset the strap pin is a general pin with a direction bit, an output-value bit and a readable pin state.
// - The reference-fail output follows the latched reference-fail flag while its enable is 1 and is low otherwise.
// - The lock output is high while the main DPLL is locked and its enable is 1, and low otherwise.
// - A loss-select bit picks the shared pin function, 0 (default) interrupt request and 1 loss of reference.
// - In interrupt mode the shared pin has selectable polarity, push-pull or open-drain drive, or acts as a plain output.
// - In loss mode the shared pin shows the live, unlatched activity-fail level of the selected reference.
`ifndef GSP_MAP_VH
`define GSP_MAP_VH

`define GSP_ADDR_W          8
`define GSP_OFS_CTRL        8'h00
`define GSP_OFS_GPIO_CFG    8'h04
`define GSP_OFS_IRQ_CFG     8'h08
`define GSP_OFS_PIN_STATE   8'h0C
`define GSP_OFS_IRQ_STATUS  8'h10
`define GSP_OFS_IRQ_CLEAR   8'h14
`define GSP_OFS_IRQ_ENABLE  8'h18

// control register fields
`define GSP_CTRL_EXT_SW     0
`define GSP_CTRL_REF_FAIL   1
`define GSP_CTRL_LOCK_PIN   2
`define GSP_CTRL_RATE_FAM   3
`define GSP_CTRL_DIG1_RATE  4
`define GSP_CTRL_DIG2_RATE  5
`define GSP_CTRL_W          6
`define GSP_CTRL_RESET      6'h06

// general pin configuration fields
`define GSP_GPC_DIR         0
`define GSP_GPC_OUT_VAL     1
`define GSP_GPC_W           2
`define GSP_GPC_RESET       2'h0

// shared pin configuration fields
`define GSP_IRQC_LOSS_SEL   0
`define GSP_IRQC_ACT_HIGH   1
`define GSP_IRQC_OPEN_DRAIN 2
`define GSP_IRQC_GPO_MODE   3
`define GSP_IRQC_GPO_VAL    4
`define GSP_IRQC_W          5
`define GSP_IRQC_RESET      5'h02

// pin state fields
`define GSP_PS_PIN4         0
`define GSP_PS_LOCKED       1
`define GSP_PS_LOSS         2
`define GSP_PS_PAIR         3
`define GSP_PS_W            4

// event status fields
`define GSP_EV_REF_FAIL     0
`define GSP_EV_LOCK_LOST    1
`define GSP_EV_LOCK_GAIN    2
`define GSP_EV_LOSS_RISE    3
`define GSP_EV_W            4
`define GSP_EV_RESET        4'h0

// reset release synchroniser depth
`define GSP_RST_SYNC_W      2

`endif

// ==== gsp_global_pins.v ====
// global reset, strap capture, status pins and shared interrupt pin with apb registers
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "gsp_map.vh"

module gsp_global_pins (
  // clock and resets
  input  wire        core_clk_in,
  input  wire        reset_in,
  input  wire        global_reset_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire [31:0] prdata_out,
  output wire        pslverr_out,
  // strap and general pin
  input  wire        fast_source_switch_in,
  input  wire        general_pin_4_in,
  output wire        general_pin_4_out,
  output wire        general_pin_4_oe_out,
  // status from the timing core
  input  wire        ref_activity_fail_in,
  input  wire        main_dpll_locked_in,
  // settings towards the timing core
  output wire        ext_switch_enable_out,
  output wire        pair_select_out,
  output wire        rate_family_strap_out,
  output wire        digital_out1_rate_sel_out,
  output wire        digital_out2_rate_sel_out,
  // status pins
  output wire        ref_fail_out,
  output wire        lock_out,
  output wire        irq_out,
  output wire        irq_oe_out,
  output wire        irq_req_out
);

  // reset synchroniser and release pulse
  reg [`GSP_RST_SYNC_W-1:0] rst_sync_ff;
  reg                       run_ff;
  wire                      run_now;
  wire                      release_now;
  wire                      soft_rst;

  // registers
  reg [`GSP_CTRL_W-1:0] ctrl_ff;
  reg [`GSP_GPC_W-1:0]  gpc_ff;
  reg [`GSP_IRQC_W-1:0] irqc_ff;
  reg [`GSP_EV_W-1:0]   ev_status_ff;
  reg [`GSP_EV_W-1:0]   ev_enable_ff;
  reg [`GSP_EV_W-1:0]   nxt_ev_status;
  reg [`GSP_EV_W-1:0]   ev_clear;
  reg [`GSP_EV_W-1:0]   ev_set;

  // apb
  reg        pready_ff;
  reg [31:0] prdata_ff;
  reg        pslverr_ff;
  reg [31:0] nxt_prdata;
  reg        nxt_pslverr;
  wire       setup_now;
  wire       wr_now;
  wire       wr_ctrl;
  wire       wr_gpc;
  wire       wr_irqc;
  wire       wr_clear;
  wire       wr_enable;

  // sampled inputs and pins
  reg  pin4_ff;
  reg  locked_ff;
  reg  loss_ff;
  reg  pair_ff;
  reg  gp_out_ff;
  reg  gp_oe_ff;
  reg  ref_fail_ff;
  reg  lock_pin_ff;
  reg  irq_pin_ff;
  reg  irq_oe_ff;
  reg  irq_req_ff;
  reg  nxt_irq_pin;
  reg  nxt_irq_oe;
  reg  nxt_gp_out;
  reg  nxt_gp_oe;
  reg  nxt_ref_fail;
  reg  nxt_lock_pin;
  reg  nxt_irq_req;
  reg  nxt_pair;
  wire irq_active;
  wire irq_level;

  // word read mux shared by the read path
  function [31:0] gsp_rd_word;
    input [7:0] addr;
    input [31:0] ctrl_w;
    input [31:0] gpc_w;
    input [31:0] irqc_w;
    input [31:0] ps_w;
    input [31:0] evs_w;
    input [31:0] eve_w;
    begin
      case (addr)
        `GSP_OFS_CTRL:       gsp_rd_word = ctrl_w;
        `GSP_OFS_GPIO_CFG:   gsp_rd_word = gpc_w;
        `GSP_OFS_IRQ_CFG:    gsp_rd_word = irqc_w;
        `GSP_OFS_PIN_STATE:  gsp_rd_word = ps_w;
        `GSP_OFS_IRQ_STATUS: gsp_rd_word = evs_w;
        `GSP_OFS_IRQ_ENABLE: gsp_rd_word = eve_w;
        default:             gsp_rd_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // address decode, clear register reads as zero but is mapped
  function gsp_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `GSP_OFS_CTRL, `GSP_OFS_GPIO_CFG, `GSP_OFS_IRQ_CFG,
        `GSP_OFS_PIN_STATE, `GSP_OFS_IRQ_STATUS,
        `GSP_OFS_IRQ_CLEAR, `GSP_OFS_IRQ_ENABLE: gsp_mapped = 1'b1;
        default:                                 gsp_mapped = 1'b0;
      endcase
    end
  endfunction

  always @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      rst_sync_ff <= {`GSP_RST_SYNC_W{1'b0}};
      run_ff      <= 1'b0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[`GSP_RST_SYNC_W-2:0], 1'b1};
      run_ff      <= rst_sync_ff[`GSP_RST_SYNC_W-1];
    end
  end

  // two flops: the pin may rise anywhere in the clock period
  assign run_now     = rst_sync_ff[`GSP_RST_SYNC_W-1];
  assign release_now = run_now & ~run_ff;
  // system reset is synchronous; the pin reset acts at once
  assign soft_rst    = reset_in | ~run_now;

  assign setup_now = psel_in & ~penable_in;
  assign wr_now    = psel_in & penable_in & pready_ff & pwrite_in;
  // writes land only at the access edge and never inside the sync window
  assign wr_ctrl   = wr_now & run_now & (paddr_in == `GSP_OFS_CTRL);
  assign wr_gpc    = wr_now & run_now & (paddr_in == `GSP_OFS_GPIO_CFG);
  assign wr_irqc   = wr_now & run_now & (paddr_in == `GSP_OFS_IRQ_CFG);
  assign wr_clear  = wr_now & run_now & (paddr_in == `GSP_OFS_IRQ_CLEAR);
  assign wr_enable = wr_now & run_now & (paddr_in == `GSP_OFS_IRQ_ENABLE);

  // apb answer is prepared in setup and stands through access
  always @* begin
    nxt_prdata  = gsp_rd_word(paddr_in,
                    {26'h0, ctrl_ff}, {30'h0, gpc_ff}, {27'h0, irqc_ff},
                    {28'h0, pair_ff, loss_ff, locked_ff, pin4_ff},
                    {28'h0, ev_status_ff}, {28'h0, ev_enable_ff});
    nxt_pslverr = ~gsp_mapped(paddr_in);
  end

  always @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (soft_rst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup_now;
      // answer stands for the one access cycle only, so idle data is always zero
      if (setup_now) begin
        prdata_ff  <= pwrite_in ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else begin
        prdata_ff  <= 32'h0000_0000;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // control registers, strap defaults land at release
  always @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      ctrl_ff      <= `GSP_CTRL_RESET;
      gpc_ff       <= `GSP_GPC_RESET;
      irqc_ff      <= `GSP_IRQC_RESET;
      ev_enable_ff <= `GSP_EV_RESET;
    end else if (reset_in) begin
      ctrl_ff      <= `GSP_CTRL_RESET;
      gpc_ff       <= `GSP_GPC_RESET;
      irqc_ff      <= `GSP_IRQC_RESET;
      ev_enable_ff <= `GSP_EV_RESET;
    end else if (release_now) begin
      ctrl_ff[`GSP_CTRL_EXT_SW]    <= fast_source_switch_in;
      ctrl_ff[`GSP_CTRL_RATE_FAM]  <= general_pin_4_in;
      ctrl_ff[`GSP_CTRL_DIG1_RATE] <= general_pin_4_in;
      ctrl_ff[`GSP_CTRL_DIG2_RATE] <= general_pin_4_in;
    end else begin
      // straps win over a write that meets the release cycle
      if (wr_ctrl) begin
        ctrl_ff <= pwdata_in[`GSP_CTRL_W-1:0];
      end
      if (wr_gpc) begin
        gpc_ff <= pwdata_in[`GSP_GPC_W-1:0];
      end
      if (wr_irqc) begin
        irqc_ff <= pwdata_in[`GSP_IRQC_W-1:0];
      end
      if (wr_enable) begin
        ev_enable_ff <= pwdata_in[`GSP_EV_W-1:0];
      end
    end
  end

  // events: set wins over a clear in the same cycle
  always @* begin
    ev_set = {`GSP_EV_W{1'b0}};
    ev_set[`GSP_EV_REF_FAIL]  = ref_activity_fail_in & ~loss_ff;
    ev_set[`GSP_EV_LOCK_LOST] = locked_ff & ~main_dpll_locked_in;
    ev_set[`GSP_EV_LOCK_GAIN] = ~locked_ff & main_dpll_locked_in;
    ev_set[`GSP_EV_LOSS_RISE] = ref_activity_fail_in & ~loss_ff;
    ev_clear = {`GSP_EV_W{1'b0}};
    if (wr_clear) begin
      ev_clear = pwdata_in[`GSP_EV_W-1:0];
    end
    nxt_ev_status = (ev_status_ff & ~ev_clear) | ev_set;
  end

  // sampled inputs and latched flags
  always @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      ev_status_ff <= `GSP_EV_RESET;
      pin4_ff      <= 1'b0;
      locked_ff    <= 1'b0;
      loss_ff      <= 1'b0;
      pair_ff      <= 1'b0;
    end else if (soft_rst) begin
      ev_status_ff <= `GSP_EV_RESET;
      pin4_ff      <= 1'b0;
      locked_ff    <= 1'b0;
      loss_ff      <= 1'b0;
      pair_ff      <= 1'b0;
    end else begin
      ev_status_ff <= nxt_ev_status;
      pin4_ff      <= general_pin_4_in;
      locked_ff    <= main_dpll_locked_in;
      loss_ff      <= ref_activity_fail_in;
      pair_ff      <= nxt_pair;
    end
  end

  // level request, stays up until software clears the flag or its enable bit
  assign irq_active = |(ev_status_ff & ev_enable_ff);
  assign irq_level  = irqc_ff[`GSP_IRQC_ACT_HIGH] ? irq_active : ~irq_active;

  // shared pin drive
  always @* begin
    if (irqc_ff[`GSP_IRQC_LOSS_SEL]) begin
      nxt_irq_pin = ref_activity_fail_in;
      nxt_irq_oe  = 1'b1;
    end else begin
      nxt_irq_pin = irqc_ff[`GSP_IRQC_GPO_MODE] ? irqc_ff[`GSP_IRQC_GPO_VAL] : irq_level;
      nxt_irq_oe  = 1'b1;
      if (irqc_ff[`GSP_IRQC_OPEN_DRAIN]) begin
        nxt_irq_oe  = ~nxt_irq_pin;
        nxt_irq_pin = 1'b0;
      end
    end
  end

  // next pin levels, every pin leaves through one flop
  always @* begin
    nxt_pair     = ctrl_ff[`GSP_CTRL_EXT_SW] & fast_source_switch_in;
    nxt_gp_out   = gpc_ff[`GSP_GPC_OUT_VAL];
    nxt_gp_oe    = gpc_ff[`GSP_GPC_DIR];
    nxt_ref_fail = ctrl_ff[`GSP_CTRL_REF_FAIL] & ev_status_ff[`GSP_EV_REF_FAIL];
    nxt_lock_pin = ctrl_ff[`GSP_CTRL_LOCK_PIN] & locked_ff;
    nxt_irq_req  = irq_active;
  end

  // pin output flops; pins stay released in reset
  always @(posedge core_clk_in or negedge global_reset_n_in) begin
    if (!global_reset_n_in) begin
      gp_out_ff   <= 1'b0;
      gp_oe_ff    <= 1'b0;
      ref_fail_ff <= 1'b0;
      lock_pin_ff <= 1'b0;
      irq_pin_ff  <= 1'b0;
      irq_oe_ff   <= 1'b0;
      irq_req_ff  <= 1'b0;
    end else if (soft_rst) begin
      gp_out_ff   <= 1'b0;
      gp_oe_ff    <= 1'b0;
      ref_fail_ff <= 1'b0;
      lock_pin_ff <= 1'b0;
      irq_pin_ff  <= 1'b0;
      irq_oe_ff   <= 1'b0;
      irq_req_ff  <= 1'b0;
    end else begin
      gp_out_ff   <= nxt_gp_out;
      gp_oe_ff    <= nxt_gp_oe;
      ref_fail_ff <= nxt_ref_fail;
      lock_pin_ff <= nxt_lock_pin;
      irq_pin_ff  <= nxt_irq_pin;
      irq_oe_ff   <= nxt_irq_oe;
      irq_req_ff  <= nxt_irq_req;
    end
  end

  assign pready_out                = pready_ff;
  assign prdata_out                = prdata_ff;
  assign pslverr_out               = pslverr_ff;
  assign general_pin_4_out         = gp_out_ff;
  assign general_pin_4_oe_out      = gp_oe_ff;
  assign ext_switch_enable_out     = ctrl_ff[`GSP_CTRL_EXT_SW];
  assign pair_select_out           = pair_ff;
  assign rate_family_strap_out     = ctrl_ff[`GSP_CTRL_RATE_FAM];
  assign digital_out1_rate_sel_out = ctrl_ff[`GSP_CTRL_DIG1_RATE];
  assign digital_out2_rate_sel_out = ctrl_ff[`GSP_CTRL_DIG2_RATE];
  assign ref_fail_out              = ref_fail_ff;
  assign lock_out                  = lock_pin_ff;
  assign irq_out                   = irq_pin_ff;
  assign irq_oe_out                = irq_oe_ff;
  assign irq_req_out               = irq_req_ff;

endmodule // gsp_global_pins

`default_nettype wire

// ==== gsp_pins_monitor.sv ====
// assertion checker for the global strap and status pin block
`timescale 1ns/1ns
`default_nettype none
module gsp_pins_monitor (
  // clock, resets and apb answer
  input wire logic        core_clk_in, reset_in, global_reset_n_in,
  input wire logic        psel_in, penable_in, pready_out, pslverr_out,
  input wire logic [31:0] prdata_out,
  // straps, pins and settings
  input wire logic        fast_source_switch_in, general_pin_4_in, main_dpll_locked_in,
  input wire logic        ext_switch_enable_out, pair_select_out, rate_family_strap_out,
  input wire logic        digital_out1_rate_sel_out, digital_out2_rate_sel_out,
  input wire logic        lock_out, irq_oe_out, general_pin_4_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in || !global_reset_n_in);
  chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_idle_data_zero: assert property (!pready_out || pslverr_out |-> !prdata_out)
    else $error("read data not zero");
  chk_pair_follow: assert property ($stable(ext_switch_enable_out) |->
    pair_select_out == (ext_switch_enable_out && $past(fast_source_switch_in)))
    else $error("pair select wrong");
  chk_lock_needs_dpll: assert property (!$past(main_dpll_locked_in, 2) |-> !lock_out)
    else $error("lock high while unlocked");
  // straps must stay put through the capture window
  chk_switch_strap: assert property ($rose(global_reset_n_in) |->
    ##5 ext_switch_enable_out == fast_source_switch_in)
    else $error("switch strap not captured");
  chk_rate_strap: assert property ($rose(global_reset_n_in) |-> ##5
    (rate_family_strap_out == general_pin_4_in && digital_out1_rate_sel_out == general_pin_4_in
    && digital_out2_rate_sel_out == general_pin_4_in))
    else $error("rate strap not captured");
  chk_sync_release: assert property ($rose(global_reset_n_in) |->
    ##1 ($stable(ext_switch_enable_out) && $stable(rate_family_strap_out))
    ##1 ($stable(ext_switch_enable_out) && $stable(rate_family_strap_out)))
    else $error("strap taken before sync");
  chk_reset_quiet: assert property (disable iff (!global_reset_n_in) reset_in |=>
    !lock_out && !irq_oe_out && !general_pin_4_oe_out)
    else $error("pins active in reset");
endmodule // gsp_pins_monitor
bind gsp_global_pins gsp_pins_monitor i_mon (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .global_reset_n_in(global_reset_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out),
  .fast_source_switch_in(fast_source_switch_in), .general_pin_4_in(general_pin_4_in),
  .main_dpll_locked_in(main_dpll_locked_in), .ext_switch_enable_out(ext_switch_enable_out),
  .pair_select_out(pair_select_out), .rate_family_strap_out(rate_family_strap_out),
  .digital_out1_rate_sel_out(digital_out1_rate_sel_out),
  .digital_out2_rate_sel_out(digital_out2_rate_sel_out),
  .lock_out(lock_out), .irq_oe_out(irq_oe_out), .general_pin_4_oe_out(general_pin_4_oe_out));
`default_nettype wire

// ==== gsp_board_model.sv ====
// board and host side model: reset pin, straps, pulled-down general pin, status inputs
`timescale 1ns/1ns
`default_nettype none
module gsp_board_model (
  // from the device
  input wire logic clk_in,
  input wire logic pin4_out_in,
  input wire logic pin4_oe_in,
  // towards the device
  output var logic rst_n_out,
  output var logic sw_out,
  output wire logic pin4_level_out,
  output var logic locked_out,
  output var logic fail_out
);
  logic drv_en, drv_val;
  // pin has a pull-down when nobody drives it
  assign pin4_level_out = pin4_oe_in ? pin4_out_in : (drv_en & drv_val);
  initial begin
    {rst_n_out, sw_out, drv_en, drv_val, locked_out, fail_out} = 6'h00;
  end
  // reset held low past two clocks, straps steady well after release
  task automatic pin_reset(input logic sw, input logic rate);
    @(posedge clk_in);
    rst_n_out <= 1'b0;
    sw_out <= sw;
    drv_val <= rate;
    drv_en <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    drv_en <= 1'b0;
  endtask
endmodule // gsp_board_model
`default_nettype wire

// ==== test_global_strap_status_pins.sv ====
// self-checking bench for the global strap and status pin block
`timescale 1ns/1ns
`default_nettype none
`include "gsp_map.vh"
module test_global_strap_status_pins;
  logic core_clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic pready_out, pslverr_out, global_reset_n_in, fast_source_switch_in, general_pin_4_in;
  logic general_pin_4_out, general_pin_4_oe_out, ref_activity_fail_in, main_dpll_locked_in;
  logic ext_switch_enable_out, pair_select_out, rate_family_strap_out, lock_out, irq_out;
  logic digital_out1_rate_sel_out, digital_out2_rate_sel_out, ref_fail_out, irq_oe_out, irq_req_out;
  logic [32:0] expq[$];
  logic [4:0] cfgs[7] = '{5'h02, 5'h00, 5'h06, 5'h04, 5'h08, 5'h18, 5'h1C};
  logic b, lv;
  int mismatches = 0, n_checks = 0, cycles = 0;
  gsp_global_pins i_dut (.core_clk_in, .reset_in, .global_reset_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
    .fast_source_switch_in, .general_pin_4_in, .general_pin_4_out, .general_pin_4_oe_out,
    .ref_activity_fail_in, .main_dpll_locked_in, .ext_switch_enable_out, .pair_select_out,
    .rate_family_strap_out, .digital_out1_rate_sel_out, .digital_out2_rate_sel_out,
    .ref_fail_out, .lock_out, .irq_out, .irq_oe_out, .irq_req_out);
  gsp_board_model i_board (.clk_in(core_clk_in), .pin4_out_in(general_pin_4_out),
    .pin4_oe_in(general_pin_4_oe_out), .rst_n_out(global_reset_n_in),
    .sw_out(fast_source_switch_in), .pin4_level_out(general_pin_4_in),
    .locked_out(main_dpll_locked_in), .fail_out(ref_activity_fail_in));
  always #2 core_clk_in = ~core_clk_in;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic pin(input logic seen, input logic exp);
    check({32'h0, seen}, {32'h0, exp});
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    if (!w) expq.push_back(e);
    cy(1);
    penable_in <= 1'b1;
    // this wait ends when pready_out is seen high; only the bench timeout ends a wait that never sees it
    do begin
      cy(1);
    end while (pready_out !== 1'b1);
    {psel_in, penable_in} <= 2'b00;
    cy(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 33'h0); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0, {1'b0, e}); endtask
  task automatic done(input string s); $display("test %s finished", s); endtask
  task automatic fail_pulse();
    i_board.fail_out <= 1'b1;
    cy(2);
    i_board.fail_out <= 1'b0;
    cy(4);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0 && expq.size() == 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read answers are compared in order, whenever the access completes
  always @(posedge core_clk_in) begin
    cycles++;
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      if (expq.size() == 0) mismatches++;
      else check({pslverr_out, prdata_out}, expq.pop_front());
    end
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h6DC15E94));
    cy(20);
    reset_in <= 1'b0;
    i_board.pin_reset(1'b1, 1'b1);
    rd(`GSP_OFS_CTRL, 32'h3F);
    rd(`GSP_OFS_IRQ_CFG, 32'h02);
    wr(`GSP_OFS_IRQ_CLEAR, 32'hF);
    rd(`GSP_OFS_IRQ_CLEAR, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
    done("straps");
    for (int i = 0; i < 6; i++) begin
      b = 1'($urandom);
      i_board.sw_out <= b;
      cy(3);
      pin(pair_select_out, b);
    end
    wr(`GSP_OFS_CTRL, 32'h3E);
    i_board.sw_out <= 1'b1;
    cy(3);
    pin(pair_select_out, 1'b0);
    i_board.sw_out <= 1'b0;
    wr(`GSP_OFS_CTRL, 32'h3F);
    for (int i = 0; i < 4; i++) begin
      b = 1'($urandom);
      wr(`GSP_OFS_GPIO_CFG, {30'h0, b, 1'b1});
      cy(2);
      pin(general_pin_4_oe_out, 1'b1);
      pin(general_pin_4_out, b);
      rd(`GSP_OFS_PIN_STATE, {31'h0, b});
      wr(`GSP_OFS_GPIO_CFG, 32'h0);
      {i_board.drv_en, i_board.drv_val} <= {1'b1, ~b};
      cy(3);
      rd(`GSP_OFS_PIN_STATE, {31'h0, ~b});
      i_board.drv_en <= 1'b0;
    end
    done("switch and general pin");
    i_board.locked_out <= 1'b1;
    cy(4);
    pin(lock_out, 1'b1);
    rd(`GSP_OFS_PIN_STATE, 32'h2);
    rd(`GSP_OFS_IRQ_STATUS, 32'h4);
    wr(`GSP_OFS_CTRL, 32'h3B);
    cy(2);
    pin(lock_out, 1'b0);
    wr(`GSP_OFS_CTRL, 32'h3F);
    i_board.locked_out <= 1'b0;
    cy(3);
    rd(`GSP_OFS_IRQ_STATUS, 32'h6);
    wr(`GSP_OFS_IRQ_CLEAR, 32'hF);
    wr(`GSP_OFS_IRQ_ENABLE, 32'h1);
    fail_pulse();
    pin(ref_fail_out, 1'b1);
    pin(irq_req_out, 1'b1);
    rd(`GSP_OFS_IRQ_STATUS, 32'h9);
    // request is high, so the pin level comes from polarity or the plain value
    foreach (cfgs[i]) begin
      wr(`GSP_OFS_IRQ_CFG, {27'h0, cfgs[i]});
      cy(2);
      lv = cfgs[i][3] ? cfgs[i][4] : cfgs[i][1];
      pin(irq_oe_out, !(cfgs[i][2] && lv));
      if (!(cfgs[i][2] && lv)) pin(irq_out, lv && !cfgs[i][2]);
    end
    wr(`GSP_OFS_IRQ_ENABLE, 32'h0);
    cy(2);
    pin(irq_req_out, 1'b0);
    wr(`GSP_OFS_IRQ_CLEAR, 32'hF);
    rd(`GSP_OFS_IRQ_STATUS, 32'h0);
    pin(ref_fail_out, 1'b0);
    wr(`GSP_OFS_CTRL, 32'h3D);
    fail_pulse();
    pin(ref_fail_out, 1'b0);
    wr(`GSP_OFS_IRQ_CFG, 32'h01);
    for (int i = 0; i < 6; i++) begin
      b = 1'($urandom);
      i_board.fail_out <= b;
      cy(3);
      pin(irq_out, b);
      pin(irq_oe_out, 1'b1);
    end
    i_board.fail_out <= 1'b0;
    done("lock and shared pins");
    wr(`GSP_OFS_CTRL, 32'h0);
    reset_in <= 1'b1;
    cy(2);
    reset_in <= 1'b0;
    cy(1);
    rd(`GSP_OFS_CTRL, 32'h06);
    i_board.pin_reset(1'b0, 1'b0);
    rd(`GSP_OFS_CTRL, 32'h06);
    rd(`GSP_OFS_IRQ_CFG, 32'h02);
    done("second resets");
    print_verdict();
  end
endmodule // test_global_strap_status_pins
`default_nettype wire
